// file: rtl/lcm_beat_capture.sv
// One byte lane of write capture on both edges of its data strobe.
// Assumes the controller centres data and mask on the strobe edges.
`timescale 1ns/1ps
`default_nettype none
module lcm_beat_capture (
  // Strobe from the controller
  input  wire logic            strobe,
  // Lane data and mask
  input  wire logic [7:0]      dq_lane,
  input  wire logic            mask,
  // Captured pair
  output lcm_pkg::lcm_beat_t   beat
);

  logic [7:0] rise_data_ff;
  logic       rise_mask_ff;
  logic [7:0] fall_data_ff;
  logic       fall_mask_ff;

  always_ff @(posedge strobe) begin
    rise_data_ff <= dq_lane;
    rise_mask_ff <= mask;
  end

  always_ff @(negedge strobe) begin
    fall_data_ff <= dq_lane;
    fall_mask_ff <= mask;
  end

  assign beat = '{rise_data: rise_data_ff, rise_mask: rise_mask_ff,
                  fall_data: fall_data_ff, fall_mask: fall_mask_ff};

endmodule : lcm_beat_capture
`default_nettype wire

// file: rtl/lcm_pkg.sv
// Constants, types and command codes for the command, address and mask interface.
// Assumes one x16 device; all link-side timing counts are in link clock cycles.
package lcm_pkg;

  localparam int ADDR_W   = 13;
  localparam int BANK_W   = 2;
  localparam int NBANKS   = 4;
  localparam int LANES    = 2;
  localparam int DQ_W     = 16;
  localparam int COL_IDX_W = 4;
  localparam int MEM_IDX_W = BANK_W + 1 + COL_IDX_W;
  localparam int MEM_WORDS = 1 << MEM_IDX_W;
  localparam int AUTO_PRE_POS = 10;

  // Mode register fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam logic [ADDR_W-1:0] MR_RESET = 13'h0032;
  localparam logic [BANK_W-1:0] MR_BANK  = 2'h0;

  // Burst length codes and pair counts
  localparam logic [2:0] BL2_CODE  = 3'h1;
  localparam logic [2:0] BL4_CODE  = 3'h2;
  localparam logic [2:0] BL8_CODE  = 3'h3;
  localparam logic [2:0] BL16_CODE = 3'h4;
  localparam logic [3:0] PAIRS_BL2  = 4'h1;
  localparam logic [3:0] PAIRS_BL4  = 4'h2;
  localparam logic [3:0] PAIRS_BL8  = 4'h4;
  localparam logic [3:0] PAIRS_BL16 = 4'h8;

  // Latencies
  localparam logic [2:0] CL2_CODE = 3'h2;
  localparam logic [2:0] CL3_CODE = 3'h3;
  localparam logic [2:0] CL_DEFAULT = 3'h3;

  localparam int CMD_COUNT_W = 16;

  typedef enum logic [3:0] {
    LCM_CMD_MRS  = 4'h0,
    LCM_CMD_REF  = 4'h1,
    LCM_CMD_PRE  = 4'h2,
    LCM_CMD_ACT  = 4'h3,
    LCM_CMD_WR   = 4'h4,
    LCM_CMD_RD   = 4'h5,
    LCM_CMD_BST  = 4'h6,
    LCM_CMD_NOP  = 4'h7
  } lcm_cmd_code_t;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BANK_W-1:0] bank_select;
    logic [ADDR_W-1:0] addr;
  } lcm_cmd_t;

  typedef struct packed {
    logic [7:0] rise_data;
    logic       rise_mask;
    logic [7:0] fall_data;
    logic       fall_mask;
  } lcm_beat_t;

endpackage : lcm_pkg

// file: rtl/lcm_sync.sv
// Two-flop level synchroniser into the core clock domain.
// Assumes each bit is an independent level from another domain.
`timescale 1ns/1ps
`default_nettype none
module lcm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : lcm_sync
`default_nettype wire

// file: rtl/lcm_top.sv
// Command decode, bank state, mode register, masked write and DDR read data.
// Assumes the controller drives the link clock and commands synchronous to it;
// the core clock only observes status through synchronisers.
`timescale 1ns/1ps
`default_nettype none
module lcm_top (
  // Core clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Link clock and command bus
  input  wire logic                          diff_clock_true,
  input  wire lcm_pkg::lcm_cmd_t             cmd_in,
  // Data lanes
  input  wire logic [lcm_pkg::DQ_W-1:0]      dq_in,
  output logic      [lcm_pkg::DQ_W-1:0]      dq_out,
  output logic                               dq_oe,
  input  wire logic [lcm_pkg::LANES-1:0]     byte_write_mask,
  // Data strobes
  input  wire logic                          lower_data_strobe_in,
  output logic                               lower_data_strobe_out,
  output logic                               lower_data_strobe_oe,
  input  wire logic                          upper_data_strobe_in,
  output logic                               upper_data_strobe_out,
  output logic                               upper_data_strobe_oe,
  // Core-side status
  output logic      [lcm_pkg::NBANKS-1:0]    bank_open,
  output logic                               power_down,
  output logic                               cmd_seen,
  output logic      [lcm_pkg::CMD_COUNT_W-1:0] cmd_count
);

  localparam int AW = lcm_pkg::ADDR_W;
  localparam int BW = lcm_pkg::BANK_W;
  localparam int CW = lcm_pkg::COL_IDX_W;
  localparam int IW = lcm_pkg::MEM_IDX_W;

  logic lclk;
  assign lclk = diff_clock_true;

  function automatic logic [3:0] burst_pairs(input logic [AW-1:0] mr);
    logic [2:0] code;
    code = mr[lcm_pkg::MR_BL_LSB +: 3];
    case (code)
      lcm_pkg::BL2_CODE:  burst_pairs = lcm_pkg::PAIRS_BL2;
      lcm_pkg::BL8_CODE:  burst_pairs = lcm_pkg::PAIRS_BL8;
      lcm_pkg::BL16_CODE: burst_pairs = lcm_pkg::PAIRS_BL16;
      default:            burst_pairs = lcm_pkg::PAIRS_BL4;
    endcase
  endfunction : burst_pairs

  function automatic logic [IW-1:0] mem_index(input logic [BW-1:0] ba, input logic row0,
                                              input logic [CW-1:0] col);
    mem_index = {ba, row0, col};
  endfunction : mem_index

  // Link reset, asserted with rst and released on the link clock
  logic lrst_meta_ff;
  logic lrst_ff;

  always_ff @(posedge lclk or posedge rst) begin
    if (rst) begin
      lrst_meta_ff <= 1'b1;
      lrst_ff      <= 1'b1;
    end else begin
      lrst_meta_ff <= 1'b0;
      lrst_ff      <= lrst_meta_ff;
    end
  end

  // Command decode on the rising crossing
  lcm_pkg::lcm_cmd_code_t cmd_code;
  logic                   cmd_valid;
  logic [BW-1:0]          cmd_bank;
  logic [AW-1:0]          cmd_addr;

  assign cmd_valid = cmd_in.cke & ~cmd_in.cs_n;
  assign cmd_code  = lcm_pkg::lcm_cmd_code_t'({cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n,
                                               cmd_in.we_n});
  assign cmd_bank  = cmd_in.bank_select;
  assign cmd_addr  = cmd_in.addr;

  logic is_act;
  logic is_pre;
  logic is_wr;
  logic is_rd;
  logic is_mrs;
  logic is_bst;

  assign is_act = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_ACT);
  assign is_pre = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_PRE);
  assign is_wr  = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_WR);
  assign is_rd  = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_RD);
  assign is_mrs = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_MRS);
  assign is_bst = cmd_valid && (cmd_code == lcm_pkg::LCM_CMD_BST);

  // Clock enable and command event
  logic cke_ff;
  logic cmd_tgl_ff;

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      cke_ff     <= 1'b1;
      cmd_tgl_ff <= 1'b0;
    end else begin
      cke_ff <= cmd_in.cke;
      if (cmd_valid && (cmd_code != lcm_pkg::LCM_CMD_NOP)) begin
        cmd_tgl_ff <= ~cmd_tgl_ff;
      end
    end
  end

  // Mode register
  logic [AW-1:0] mr_ff;
  logic [3:0]    pairs;
  logic [2:0]    cas_lat;

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      mr_ff <= lcm_pkg::MR_RESET;
    end else if (is_mrs && (cmd_bank == lcm_pkg::MR_BANK)) begin
      mr_ff <= cmd_addr;
    end
  end

  assign pairs   = burst_pairs(mr_ff);
  assign cas_lat = (mr_ff[lcm_pkg::MR_CL_LSB +: 3] == lcm_pkg::CL2_CODE) ? lcm_pkg::CL2_CODE :
                   (mr_ff[lcm_pkg::MR_CL_LSB +: 3] == lcm_pkg::CL3_CODE) ? lcm_pkg::CL3_CODE :
                   lcm_pkg::CL_DEFAULT;

  // Write burst sequencing
  logic          wr_dly_ff;
  logic          wr_act_ff;
  logic [3:0]    wr_left_ff;
  logic [BW-1:0] wr_bank_ff;
  logic [CW-1:0] wr_col_ff;
  logic          wr_auto_pre_ff;
  logic          wr_last;

  assign wr_last = wr_act_ff && (wr_left_ff == 4'h1);

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      wr_dly_ff      <= 1'b0;
      wr_act_ff      <= 1'b0;
      wr_left_ff     <= 4'h0;
      wr_bank_ff     <= '0;
      wr_col_ff      <= '0;
      wr_auto_pre_ff <= 1'b0;
    end else begin
      wr_dly_ff <= is_wr;
      if (is_wr || is_rd || is_bst) begin
        wr_act_ff <= 1'b0;
      end else if (wr_dly_ff) begin
        wr_act_ff  <= 1'b1;
        wr_left_ff <= pairs;
      end else if (wr_act_ff) begin
        wr_left_ff <= wr_left_ff - 4'h1;
        wr_col_ff  <= wr_col_ff + CW'(2);
        if (wr_last) begin
          wr_act_ff <= 1'b0;
        end
      end
      if (is_wr) begin
        wr_bank_ff     <= cmd_bank;
        wr_col_ff      <= cmd_addr[CW-1:0];
        wr_auto_pre_ff <= cmd_addr[lcm_pkg::AUTO_PRE_POS];
      end
    end
  end

  // Read burst sequencing
  logic [2:0]    rd_wait_ff;
  logic [3:0]    rd_left_ff;
  logic          rd_oe_ff;
  logic [BW-1:0] rd_bank_ff;
  logic [CW-1:0] rd_col_ff;
  logic          rd_auto_pre_ff;
  logic          rd_load;
  logic          rd_next;
  logic          rd_done;

  assign rd_load = (rd_wait_ff == 3'h1);
  assign rd_next = rd_oe_ff && (rd_left_ff != 4'h0);
  assign rd_done = rd_oe_ff && (rd_left_ff == 4'h0) && !rd_load;

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      rd_wait_ff     <= 3'h0;
      rd_left_ff     <= 4'h0;
      rd_oe_ff       <= 1'b0;
      rd_bank_ff     <= '0;
      rd_col_ff      <= '0;
      rd_auto_pre_ff <= 1'b0;
    end else begin
      if (is_rd) begin
        rd_wait_ff     <= cas_lat;
        rd_bank_ff     <= cmd_bank;
        rd_col_ff      <= cmd_addr[CW-1:0];
        rd_auto_pre_ff <= cmd_addr[lcm_pkg::AUTO_PRE_POS];
      end else if (is_bst || is_wr) begin
        rd_wait_ff <= 3'h0;
      end else if (rd_wait_ff != 3'h0) begin
        rd_wait_ff <= rd_wait_ff - 3'h1;
      end
      if ((is_bst || is_wr) && !rd_load) begin
        rd_oe_ff   <= 1'b0;
        rd_left_ff <= 4'h0;
      end else if (rd_load) begin
        rd_oe_ff   <= 1'b1;
        rd_left_ff <= pairs - 4'h1;
      end else if (rd_next) begin
        rd_left_ff <= rd_left_ff - 4'h1;
        rd_col_ff  <= rd_col_ff + CW'(2);
      end else begin
        rd_oe_ff <= 1'b0;
      end
    end
  end

  // Bank state
  logic [lcm_pkg::NBANKS-1:0] open_ff;
  logic [AW-1:0]              row_ff [lcm_pkg::NBANKS];

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      open_ff <= '0;
      for (int b = 0; b < lcm_pkg::NBANKS; b++) begin
        row_ff[b] <= '0;
      end
    end else begin
      if (wr_last && wr_auto_pre_ff) begin
        open_ff[wr_bank_ff] <= 1'b0;
      end
      if (rd_done && rd_auto_pre_ff) begin
        open_ff[rd_bank_ff] <= 1'b0;
      end
      if (is_act) begin
        open_ff[cmd_bank] <= 1'b1;
        row_ff[cmd_bank]  <= cmd_addr;
      end else if (is_pre) begin
        if (cmd_addr[lcm_pkg::AUTO_PRE_POS]) begin
          open_ff <= '0;
        end else begin
          open_ff[cmd_bank] <= 1'b0;
        end
      end
    end
  end

  // Write capture per lane on the strobes
  lcm_pkg::lcm_beat_t beat_lo;
  lcm_pkg::lcm_beat_t beat_hi;

  lcm_beat_capture u_cap_lo (
    .strobe  (lower_data_strobe_in),
    .dq_lane (dq_in[7:0]),
    .mask    (byte_write_mask[0]),
    .beat    (beat_lo)
  );

  lcm_beat_capture u_cap_hi (
    .strobe  (upper_data_strobe_in),
    .dq_lane (dq_in[15:8]),
    .mask    (byte_write_mask[1]),
    .beat    (beat_hi)
  );

  // Storage, written one beat pair per link cycle
  logic [lcm_pkg::DQ_W-1:0] mem_ff [lcm_pkg::MEM_WORDS];
  logic [IW-1:0]            wr_idx0;
  logic [IW-1:0]            wr_idx1;

  assign wr_idx0 = mem_index(wr_bank_ff, row_ff[wr_bank_ff][0], wr_col_ff);
  assign wr_idx1 = mem_index(wr_bank_ff, row_ff[wr_bank_ff][0], wr_col_ff + CW'(1));

  always_ff @(posedge lclk) begin
    if (wr_act_ff) begin
      if (!beat_lo.rise_mask) begin
        mem_ff[wr_idx0][7:0] <= beat_lo.rise_data;
      end
      if (!beat_hi.rise_mask) begin
        mem_ff[wr_idx0][15:8] <= beat_hi.rise_data;
      end
      if (!beat_lo.fall_mask) begin
        mem_ff[wr_idx1][7:0] <= beat_lo.fall_data;
      end
      if (!beat_hi.fall_mask) begin
        mem_ff[wr_idx1][15:8] <= beat_hi.fall_data;
      end
    end
  end

  // Read data pair loaded on the rising edge, driven across both phases
  logic [lcm_pkg::DQ_W-1:0] rise_out_ff;
  logic [lcm_pkg::DQ_W-1:0] fall_out_ff;
  logic [CW-1:0]            rd_col;
  logic [IW-1:0]            rd_idx0;
  logic [IW-1:0]            rd_idx1;

  assign rd_col  = rd_load ? rd_col_ff : rd_col_ff + CW'(2);
  assign rd_idx0 = mem_index(rd_bank_ff, row_ff[rd_bank_ff][0], rd_col);
  assign rd_idx1 = mem_index(rd_bank_ff, row_ff[rd_bank_ff][0], rd_col + CW'(1));

  always_ff @(posedge lclk or posedge lrst_ff) begin
    if (lrst_ff) begin
      rise_out_ff <= '0;
      fall_out_ff <= '0;
    end else if (rd_load || rd_next) begin
      rise_out_ff <= mem_ff[rd_idx0];
      fall_out_ff <= mem_ff[rd_idx1];
    end
  end

  logic drive;
  assign drive = rd_oe_ff & cke_ff;

  assign dq_out                = lclk ? rise_out_ff : fall_out_ff;
  assign dq_oe                 = drive;
  assign lower_data_strobe_out = drive & lclk;
  assign lower_data_strobe_oe  = drive;
  assign upper_data_strobe_out = drive & lclk;
  assign upper_data_strobe_oe  = drive;

  // Status into the core domain
  logic [lcm_pkg::NBANKS+1:0] stat_sync;
  logic                       tgl_prev_ff;

  lcm_sync #(
    .W (lcm_pkg::NBANKS + 2)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({cmd_tgl_ff, ~cke_ff, open_ff}),
    .q   (stat_sync)
  );

  assign bank_open  = stat_sync[lcm_pkg::NBANKS-1:0];
  assign power_down = stat_sync[lcm_pkg::NBANKS];
  assign cmd_seen   = stat_sync[lcm_pkg::NBANKS+1] ^ tgl_prev_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_prev_ff <= 1'b0;
      cmd_count   <= '0;
    end else begin
      tgl_prev_ff <= stat_sync[lcm_pkg::NBANKS+1];
      if (cmd_seen) begin
        cmd_count <= cmd_count + 16'h0001;
      end
    end
  end

endmodule : lcm_top
`default_nettype wire

// file: verification/lcm_ctrl_model.sv
// Memory controller model: free-running link clock, commands, write bursts, read capture.
// Assumes data and strobe lines are resolved against the device enables outside.
`timescale 1ns/1ps
`default_nettype none
module lcm_ctrl_model (
  // Link clock and command
  output logic                          ck,
  output lcm_pkg::lcm_cmd_t             cmd,
  // Write data
  output logic [15:0]                   dq,
  output logic [1:0]                    mask,
  output logic                          dqs,
  // Read return
  input  wire logic [15:0]              dq_rd,
  input  wire logic                     oe
);
  initial begin
    ck   = 1'b0;
    cmd  = {1'b1, 4'hf, 2'h0, 13'h0000};
    dq   = 16'h0000;
    mask = 2'h0;
    dqs  = 1'b0;
    forever #7.5 ck = ~ck;
  end

  task automatic issue(input logic ke, input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    @(negedge ck);
    cmd <= {ke, c, b, a};
    @(negedge ck);
    cmd <= {ke, 4'h7, 2'h0, 13'h0000};
  endtask : issue

  // Four beats, strobe edges centred in each beat
  task automatic wr_data(input logic [63:0] d, input logic [7:0] m);
    @(posedge ck);
    for (int i = 0; i < 4; i++) begin
      dq   = d[16*i +: 16];
      mask = m[2*i +: 2];
      #3.75 dqs = ~dqs;
      #3.75;
    end
    dq   = ~dq;
    mask = ~mask;
  endtask : wr_data

  task automatic rd_data(output logic [63:0] q, output int p);
    q = '0;
    p = 0;
    for (int t = 0; t < 8; t++) begin
      @(posedge ck);
      #3.75;
      if (oe === 1'b1) begin
        q[32*p +: 16] = dq_rd;
        #7.5;
        q[32*p+16 +: 16] = dq_rd;
        p++;
      end
    end
  endtask : rd_data
endmodule : lcm_ctrl_model
`default_nettype wire

// file: verification/lcm_top_chk.sv
// Checker for the command, read-enable, clock-enable and command-count behaviour at the top ports.
// Assumes the mode register keeps a read latency of three link cycles throughout the run.
`timescale 1ns/1ps
`default_nettype none
module lcm_top_chk (
  // Clocks and reset
  input wire logic                              clk,
  input wire logic                              rst,
  input wire logic                              diff_clock_true,
  // Link side
  input wire lcm_pkg::lcm_cmd_t                 cmd_in,
  input wire logic                              dq_oe,
  input wire logic                              lower_data_strobe_oe,
  input wire logic                              upper_data_strobe_oe,
  input wire logic                              lower_data_strobe_out,
  input wire logic                              upper_data_strobe_out,
  // Core side
  input wire logic                              power_down,
  input wire logic                              cmd_seen,
  input wire logic [lcm_pkg::CMD_COUNT_W-1:0]   cmd_count
);
  logic [4:0] code;
  logic       rd_go;
  logic       stop;
  assign code  = {cmd_in.cke, cmd_in.cs_n, cmd_in.ras_n, cmd_in.cas_n, cmd_in.we_n};
  assign rd_go = code == 5'h15;
  // A new read, write or burst stop restarts or ends the burst
  assign stop  = code == 5'h14 || code == 5'h15 || code == 5'h16;

  a_strobe_oe_tie: assert property (@(posedge diff_clock_true) disable iff (rst)
    lower_data_strobe_oe == dq_oe && upper_data_strobe_oe == dq_oe) else $error("strobe enable differs");
  a_read_cas_lat: assert property (@(posedge diff_clock_true) disable iff (rst)
    rd_go ##1 (cmd_in.cke && !stop) [*3] |=> dq_oe) else $error("read data late");
  a_oe_from_read: assert property (@(posedge diff_clock_true) disable iff (rst)
    $rose(dq_oe) |-> $past(rd_go, 4)) else $error("drive without read");
  a_strobe_high: assert property (@(negedge diff_clock_true) disable iff (rst)
    lower_data_strobe_out == dq_oe && upper_data_strobe_out == dq_oe) else $error("strobe not high with data");
  a_strobe_low: assert property (@(posedge diff_clock_true) disable iff (rst)
    !lower_data_strobe_out && !upper_data_strobe_out) else $error("strobe high in low phase");
  a_burst_bounded: assert property (@(posedge diff_clock_true) disable iff (rst)
    $rose(dq_oe) |-> ##[1:8] !dq_oe) else $error("burst too long");
  a_cke_quiets: assert property (@(posedge diff_clock_true) disable iff (rst)
    !$past(cmd_in.cke) |-> !dq_oe) else $error("drive with clock enable low");
  a_pd_enter: assert property (@(posedge clk) disable iff (rst)
    !cmd_in.cke [*6] |-> power_down) else $error("no power down");
  a_pd_exit: assert property (@(posedge clk) disable iff (rst)
    cmd_in.cke [*6] |-> !power_down) else $error("power down stuck");
  a_count_step: assert property (@(posedge clk) disable iff (rst)
    cmd_count == 16'($past(cmd_count) + 16'($past(cmd_seen)))) else $error("count step wrong");

  c_read: cover property (@(posedge diff_clock_true) disable iff (rst) $rose(dq_oe));
  c_pd: cover property (@(posedge clk) disable iff (rst) $rose(power_down));
  c_seen: cover property (@(posedge clk) disable iff (rst) cmd_seen);
endmodule : lcm_top_chk

bind lcm_top lcm_top_chk u_lcm_top_chk (.clk, .rst, .diff_clock_true, .cmd_in, .dq_oe,
  .lower_data_strobe_oe, .upper_data_strobe_oe, .lower_data_strobe_out, .upper_data_strobe_out,
  .power_down, .cmd_seen, .cmd_count);
`default_nettype wire

// file: verification/lcm_top_tb_top.sv
// Testbench top: device block against the controller model, core clock made here.
// Assumes the checker is bound into the device block by its own file.
`timescale 1ns/1ps
`default_nettype none
module lcm_top_tb_top;
  logic                 clk;
  logic                 rst;
  logic                 ck;
  lcm_pkg::lcm_cmd_t    cmd;
  logic [15:0]          cdq;
  logic [15:0]          dq_out;
  logic [1:0]           mask;
  logic                 dqs;
  logic                 dq_oe;
  logic                 ls_o;
  logic                 ls_oe;
  logic                 us_o;
  logic                 us_oe;
  logic [3:0]           bank_open;
  logic                 power_down;
  logic                 cmd_seen;
  logic [15:0]          cmd_count;
  int                   errors;
  int                   n_checks;

  lcm_top u_lcm_top (
    .clk(clk), .rst(rst), .diff_clock_true(ck), .cmd_in(cmd),
    .dq_in(dq_oe ? dq_out : cdq), .dq_out(dq_out), .dq_oe(dq_oe), .byte_write_mask(mask),
    .lower_data_strobe_in(ls_oe ? ls_o : dqs), .lower_data_strobe_out(ls_o), .lower_data_strobe_oe(ls_oe),
    .upper_data_strobe_in(us_oe ? us_o : dqs), .upper_data_strobe_out(us_o), .upper_data_strobe_oe(us_oe),
    .bank_open(bank_open), .power_down(power_down), .cmd_seen(cmd_seen), .cmd_count(cmd_count));

  lcm_ctrl_model u_lcm_ctrl_model (
    .ck(ck), .cmd(cmd), .dq(cdq), .mask(mask), .dqs(dqs), .dq_rd(dq_out), .oe(dq_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  task automatic go(input logic ke, input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    u_lcm_ctrl_model.issue(ke, c, b, a);
    settle();
  endtask : go

  task automatic s_banks();
    go(1'b1, 4'h3, 2'h2, 13'h0001);
    check(bank_open === 4'h4, "open bank 2");
    go(1'b1, 4'hb, 2'h1, 13'h0001);
    check(bank_open === 4'h4, "deselected activate");
    go(1'b0, 4'h3, 2'h0, 13'h0001);
    repeat (8) @(posedge clk);
    check(power_down === 1'b1, "power down entry");
    check(bank_open === 4'h4, "activate in power down");
    go(1'b1, 4'h7, 2'h0, 13'h0000);
    check(power_down === 1'b0, "power down exit");
    go(1'b1, 4'h2, 2'h2, 13'h0000);
    check(bank_open === 4'h0, "close bank 2");
    go(1'b1, 4'h3, 2'h0, 13'h0001);
    go(1'b1, 4'h3, 2'h3, 13'h0001);
    check(bank_open === 4'h9, "open banks 0 and 3");
    go(1'b1, 4'h2, 2'h0, 13'h0400);
    check(bank_open === 4'h0, "close all");
    settle();
    check(cmd_count === 16'h0005, "command count");
  endtask : s_banks

  task automatic s_write();
    logic [63:0] q;
    int          p;
    go(1'b1, 4'h3, 2'h1, 13'h0001);
    u_lcm_ctrl_model.issue(1'b1, 4'h4, 2'h1, 13'h0004);
    u_lcm_ctrl_model.wr_data(64'h4444_3333_2222_1111, 8'h00);
    u_lcm_ctrl_model.issue(1'b1, 4'h4, 2'h1, 13'h0004);
    u_lcm_ctrl_model.wr_data(64'hdddd_cccc_bbbb_aaaa, 8'he4);
    u_lcm_ctrl_model.issue(1'b1, 4'h5, 2'h1, 13'h0404);
    u_lcm_ctrl_model.rd_data(q, p);
    check(q === 64'h4444_33cc_bb22_aaaa, "masked write merge");
    check(p == 2, "read pairs");
    settle();
    check(bank_open === 4'h0, "auto precharge");
  endtask : s_write

  task automatic s_mode();
    logic [63:0] q;
    int          p;
    go(1'b1, 4'h3, 2'h0, 13'h0001);
    u_lcm_ctrl_model.issue(1'b1, 4'h4, 2'h0, 13'h0000);
    u_lcm_ctrl_model.wr_data(64'h8888_7777_6666_5555, 8'h00);
    go(1'b1, 4'h0, 2'h1, 13'h0031);
    u_lcm_ctrl_model.issue(1'b1, 4'h5, 2'h0, 13'h0000);
    u_lcm_ctrl_model.rd_data(q, p);
    check(p == 2, "mode set to bank 1 refused");
    go(1'b1, 4'h0, 2'h0, 13'h0031);
    u_lcm_ctrl_model.issue(1'b1, 4'h5, 2'h0, 13'h0000);
    u_lcm_ctrl_model.rd_data(q, p);
    check(p == 1 && q[31:0] === 32'h6666_5555, "burst of two");
    u_lcm_ctrl_model.issue(1'b1, 4'h5, 2'h0, 13'h0000);
    u_lcm_ctrl_model.issue(1'b1, 4'h6, 2'h0, 13'h0000);
    u_lcm_ctrl_model.rd_data(q, p);
    check(p == 0, "burst stop before data");
  endtask : s_mode

  initial begin
    errors   = 0;
    n_checks = 0;
    rst      = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    settle();
    s_banks();
    s_write();
    s_mode();
    tally_and_finish();
  end

  // Watchdog well beyond the few microseconds of traffic
  initial begin
    #50000;
    errors++;
    tally_and_finish();
  end
endmodule : lcm_top_tb_top
`default_nettype wire
